// ===== rtl/lbcs_map.svh
// timing counts, register offsets and field positions for the led sequencer
`ifndef LBCS_MAP_SVH
`define LBCS_MAP_SVH

// ------------------------------------------------------------
// clocks
// ------------------------------------------------------------
`define LBCS_CLK_MHZ 40
`define LBCS_CLK_HZ 40000000
`define LBCS_SW_HZ 1200000
`define LBCS_SW_DIV (`LBCS_CLK_HZ / `LBCS_SW_HZ)
// least times round up, longest times round down
`define LBCS_CYC_MIN(t) ((((t) * `LBCS_CLK_MHZ) + 999) / 1000)
`define LBCS_CYC_MAX(t) (((t) * `LBCS_CLK_MHZ) / 1000)
`define LBCS_CW 18

// ------------------------------------------------------------
// device times in ns, ramp step in us
// ------------------------------------------------------------
`define LBCS_T_START_NS 2000
`define LBCS_T_PH_MAX_NS 360000
`define LBCS_T_ACK_NS 512000
`define LBCS_T_STEP_US 213
`define LBCS_RAMP_STEPS 32
`define LBCS_T_HALF_NS 5000000
`define LBCS_OLP_CYC 8
`define LBCS_T_OFF_NS 2500000
`define LBCS_T_DLY_NS 100000
`define LBCS_T_DET_NS 260000
`define LBCS_T_WIN_NS 1000000
// ramp step in switching cycles, rounded up
`define LBCS_STEP_SW (((`LBCS_T_STEP_US * `LBCS_SW_HZ) + 999999) / 1000000)
`define LBCS_FRAME_BITS 8
`define LBCS_ACK_REQ_BIT 7
`define LBCS_LVL_RST 5'h1F

// ------------------------------------------------------------
// host times in ns
// ------------------------------------------------------------
`define LBCS_H_SHORT_NS 4000
`define LBCS_H_LONG_NS 12000
`define LBCS_H_START_NS 10000
`define LBCS_H_EOS_NS 4000
`define LBCS_H_SMP_NS 8000
`define LBCS_H_DDLY_NS 150000
`define LBCS_H_DLOW_NS 300000

// ------------------------------------------------------------
// host registers
// ------------------------------------------------------------
`define LBCS_ADR_TX 8'h00
`define LBCS_ADR_LINE 8'h04
`define LBCS_ADR_STAT 8'h08
`define LBCS_LINE_LVL 0
`define LBCS_LINE_DET 1

`endif

// ===== rtl/lbcs_pkg.sv
// state types of the led sequencer ends
package lbcs_pkg;
    typedef enum logic [1:0] {DEV_OFF, DEV_DETECT, DEV_RUN} lbcs_dev_st_t;
    typedef enum logic [3:0] {
        H_IDLE, H_START, H_LO, H_HI, H_EOS, H_ACKW, H_ACKS, H_DDLY, H_DLOW
    } lbcs_host_st_t;
endpackage : lbcs_pkg

// ===== rtl/lbcs_if.sv
// control line shared by host and device, with its pull-up
`timescale 1ns/1ps
`default_nettype none
interface lbcs_if;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic line;
    // released line is pulled high; device only ever pulls low
    assign line = (dev_oe && !dev_o) ? 1'b0 : (host_oe ? host_o : 1'b1);
    modport dev_mp (output dev_o, output dev_oe, input line);
    modport host_mp (output host_o, output host_oe, input line);
endinterface : lbcs_if
`default_nettype wire

// ===== rtl/lbcs_phase_meter.sv
// control line synchroniser and phase length counter
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_map.svh"
module lbcs_phase_meter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic line_i,
    output logic lvl_o,
    output logic rise_o,
    output logic fall_o,
    output logic [`LBCS_CW-1:0] len_o,
    output logic [`LBCS_CW-1:0] run_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic edge_w;

    always_ff @(posedge clk_i) begin
        s1_q <= line_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    assign edge_w = s2_q ^ s3_q;
    assign lvl_o = s3_q;

    // saturates so a held line never wraps into a short phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_o <= '0;
        end else if (edge_w) begin
            run_o <= `LBCS_CW'(1);
        end else if (run_o != '1) begin
            run_o <= run_o + `LBCS_CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_o <= 1'b0;
            fall_o <= 1'b0;
            len_o <= '0;
        end else begin
            rise_o <= s2_q && !s3_q;
            fall_o <= !s2_q && s3_q;
            if (edge_w) begin
                len_o <= run_o;
            end
        end
    end
endmodule : lbcs_phase_meter
`default_nettype wire

// ===== rtl/lbcs_device.sv
// led boost sequencer: control line decoder, soft start and protection
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_map.svh"
// Summary of operation
// - host holds start level 2 us first
// - host ends stream, 2 to 360 us
// - zero bit: short high after long low
// - one bit: long high after short low
// - acknowledge only when ack request flag set
// - ack within 2 us, held below 512 us
// - host pull-up restores released line high
// - reference ramps in 32 steps of 213 us
// - half current limit for first 5 ms
// - 8 cycles overvoltage with low feedback faults
// - fault stays latched until line toggles
// - undervoltage holds shutdown, restart on clear
// - over-temperature off, resumes by itself
// - line low over 2.5 ms shuts down
// - 1.2 MHz switching tick times protection, ramp
// - duty dimming default at every enable
// - one-wire chosen by timed low in window
// - dimming mode kept until shutdown
// - duty mode reference is high fraction scaled
module lbcs_device import lbcs_pkg::*; #(
    parameter logic [`LBCS_CW-1:0] OFF_CYC =
        `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_T_OFF_NS)),
    parameter logic [`LBCS_CW-1:0] HALF_CYC =
        `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_T_HALF_NS)),
    parameter logic [`LBCS_CW-1:0] WIN_CYC =
        `LBCS_CW'(`LBCS_CYC_MAX(`LBCS_T_WIN_NS)),
    parameter logic [`LBCS_CW-1:0] DET_CYC =
        `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_T_DET_NS)),
    parameter logic [`LBCS_CW-1:0] ACK_CYC =
        `LBCS_CW'(`LBCS_CYC_MAX(`LBCS_T_ACK_NS)),
    parameter logic [`LBCS_CW-1:0] PH_MAX_CYC =
        `LBCS_CW'(`LBCS_CYC_MAX(`LBCS_T_PH_MAX_NS))
) (
    input wire logic clk_i,
    input wire logic rst_i,
    lbcs_if.dev_mp link,
    input wire logic ovp_i,
    input wire logic fb_low_i,
    input wire logic uvlo_i,
    input wire logic otp_i,
    output logic switch_en_o,
    output logic ilim_half_o,
    output logic [7:0] ref_code_o,
    output logic onewire_o,
    output logic fault_o
);
    // ------------------------------------------------------------
    // line measurement
    // ------------------------------------------------------------
    logic lvl;
    logic rise;
    logic fall;
    logic [`LBCS_CW-1:0] len;
    logic [`LBCS_CW-1:0] run;

    lbcs_phase_meter u_meter (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .line_i (link.line),
        .lvl_o (lvl),
        .rise_o (rise),
        .fall_o (fall),
        .len_o (len),
        .run_o (run)
    );

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    lbcs_dev_st_t st_q;
    logic [`LBCS_CW-1:0] win_q;
    logic det_ok_q;
    logic onewire_q;
    logic fault_q;
    logic active;
    logic long_low;
    logic olp_trip;
    logic [5:0] div_q;
    logic sw_tick;
    logic [5:0] step_q;
    logic [8:0] scnt_q;
    logic [`LBCS_CW-1:0] hcnt_q;
    logic [2:0] olp_q;
    logic [7:0] pn_q;
    logic [7:0] acc_q;
    logic [7:0] duty_q;
    logic rx_on_q;
    logic [3:0] bits_q;
    logic [7:0] sh_q;
    logic [`LBCS_CW-1:0] low_len_q;
    logic one_b;
    logic zero_b;
    logic frame_done;
    logic [7:0] word;
    logic [4:0] lvl_q;
    logic ack_q;
    logic [`LBCS_CW-1:0] acnt_q;
    logic [7:0] target;
    logic [13:0] prod;

    assign long_low = !lvl && (run > OFF_CYC);
    assign active = (st_q != DEV_OFF) && !uvlo_i && !otp_i;

    // ------------------------------------------------------------
    // enable and mode detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= DEV_OFF;
            onewire_q <= 1'b0;
        end else if (long_low || olp_trip) begin
            st_q <= DEV_OFF;
        end else begin
            case (st_q)
                DEV_OFF: begin
                    if (rise) begin
                        st_q <= DEV_DETECT;
                        onewire_q <= 1'b0;
                    end
                end
                DEV_DETECT: begin
                    if (!lvl && det_ok_q && run > DET_CYC) begin
                        st_q <= DEV_RUN;
                        onewire_q <= 1'b1;
                    end else if (win_q >= WIN_CYC) begin
                        st_q <= DEV_RUN;
                    end
                end
                DEV_RUN: begin
                    st_q <= DEV_RUN;
                end
                default: begin
                    st_q <= DEV_OFF;
                end
            endcase
        end
    end

    // window starts at the enabling rise; low must begin after the delay
    always_ff @(posedge clk_i) begin
        if (rst_i || st_q != DEV_DETECT) begin
            win_q <= '0;
            det_ok_q <= 1'b0;
        end else begin
            win_q <= win_q + `LBCS_CW'(1);
            if (fall) begin
                det_ok_q <= win_q >=
                    `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_T_DLY_NS));
            end
        end
    end

    // ------------------------------------------------------------
    // switching tick, soft start, current limit
    // ------------------------------------------------------------
    assign sw_tick = (div_q == 6'(`LBCS_SW_DIV - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || sw_tick) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end

    // ramp restarts whenever the device is held off, so every restart is soft
    always_ff @(posedge clk_i) begin
        if (rst_i || !active) begin
            step_q <= 6'h00;
            scnt_q <= 9'h000;
        end else if (sw_tick && step_q != 6'(`LBCS_RAMP_STEPS)) begin
            if (scnt_q == 9'(`LBCS_STEP_SW - 1)) begin
                scnt_q <= 9'h000;
                step_q <= step_q + 6'h01;
            end else begin
                scnt_q <= scnt_q + 9'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !active) begin
            hcnt_q <= '0;
        end else if (hcnt_q != HALF_CYC) begin
            hcnt_q <= hcnt_q + `LBCS_CW'(1);
        end
    end

    // ------------------------------------------------------------
    // open led protection
    // ------------------------------------------------------------
    assign olp_trip = active && sw_tick && ovp_i && fb_low_i &&
        (olp_q == 3'(`LBCS_OLP_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || !active) begin
            olp_q <= 3'h0;
        end else if (sw_tick) begin
            olp_q <= (ovp_i && fb_low_i) ? olp_q + 3'h1 : 3'h0;
        end
    end

    // a trip in the same cycle as a toggle still latches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
        end else if (olp_trip) begin
            fault_q <= 1'b1;
        end else if (rise) begin
            fault_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // duty measurement over 255 switching ticks
    // ------------------------------------------------------------
    // duty below about 5 kHz beats against this window and wobbles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pn_q <= 8'h00;
            acc_q <= 8'h00;
            duty_q <= 8'h00;
        end else if (sw_tick) begin
            if (pn_q == 8'hFE) begin
                pn_q <= 8'h00;
                acc_q <= 8'h00;
                duty_q <= 8'(acc_q + {7'h00, lvl});
            end else begin
                pn_q <= pn_q + 8'h01;
                acc_q <= 8'(acc_q + {7'h00, lvl});
            end
        end
    end

    // ------------------------------------------------------------
    // one-wire frame decoder
    // ------------------------------------------------------------
    // the longer phase must be at least twice the shorter; equal phases are refused
    assign one_b = {1'b0, len} >= {low_len_q, 1'b0};
    assign zero_b = {1'b0, low_len_q} >= {len, 1'b0};
    assign word = {sh_q[6:0], one_b};
    assign frame_done = fall && rx_on_q && (one_b || zero_b) &&
        (bits_q == 4'(`LBCS_FRAME_BITS - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i || st_q != DEV_RUN || !onewire_q) begin
            rx_on_q <= 1'b0;
            bits_q <= 4'h0;
            sh_q <= 8'h00;
            low_len_q <= '0;
        end else if (rx_on_q && run > PH_MAX_CYC) begin
            rx_on_q <= 1'b0;
        end else if (fall) begin
            if (!rx_on_q) begin
                rx_on_q <= len >=
                    `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_T_START_NS));
                bits_q <= 4'h0;
            end else if (one_b || zero_b) begin
                sh_q <= word;
                bits_q <= bits_q + 4'h1;
                rx_on_q <= !frame_done;
            end else begin
                rx_on_q <= 1'b0;
            end
        end else if (rise && rx_on_q) begin
            low_len_q <= len;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || st_q == DEV_OFF) begin
            lvl_q <= `LBCS_LVL_RST;
        end else if (frame_done) begin
            lvl_q <= word[4:0];
        end
    end

    // ------------------------------------------------------------
    // acknowledge, open drain low
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            acnt_q <= '0;
        end else if (frame_done && word[`LBCS_ACK_REQ_BIT]) begin
            ack_q <= 1'b1;
            acnt_q <= '0;
        end else if (ack_q) begin
            if (acnt_q == ACK_CYC - `LBCS_CW'(1)) begin
                ack_q <= 1'b0;
            end else begin
                acnt_q <= acnt_q + `LBCS_CW'(1);
            end
        end
    end

    assign link.dev_oe = ack_q;
    assign link.dev_o = 1'b0;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign target = onewire_q ? {lvl_q, lvl_q[4:2]} : duty_q;
    assign prod = {6'h00, target} * {8'h00, step_q};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            switch_en_o <= 1'b0;
            ilim_half_o <= 1'b0;
            ref_code_o <= 8'h00;
            onewire_o <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            switch_en_o <= active && !olp_trip;
            ilim_half_o <= active && (hcnt_q != HALF_CYC);
            ref_code_o <= active ? prod[12:5] : 8'h00;
            onewire_o <= onewire_q;
            fault_o <= fault_q;
        end
    end
endmodule : lbcs_device
`default_nettype wire

// ===== rtl/lbcs_host.sv
// host end: wishbone registers driving the one-wire control line
`timescale 1ns/1ps
`default_nettype none
`include "lbcs_map.svh"
module lbcs_host import lbcs_pkg::*; #(
    parameter logic [`LBCS_CW-1:0] DDLY_CYC =
        `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_DDLY_NS)),
    parameter logic [`LBCS_CW-1:0] DLOW_CYC =
        `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_DLOW_NS)),
    parameter logic [`LBCS_CW-1:0] ACKMAX_CYC =
        `LBCS_CW'(`LBCS_CYC_MAX(`LBCS_T_ACK_NS))
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    lbcs_if.host_mp link
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    lbcs_host_st_t st_q;
    logic [`LBCS_CW-1:0] cnt_q;
    logic [`LBCS_CW-1:0] lim;
    logic tdone;
    logic [7:0] sh_q;
    logic [2:0] bit_q;
    logic idle_q;
    logic ack_seen_q;
    logic ls1_q;
    logic ls2_q;
    logic drv_q;
    logic oe_q;
    logic wr;
    logic go_tx;
    logic go_det;
    logic [`LBCS_CW-1:0] short_c;
    logic [`LBCS_CW-1:0] long_c;

    assign short_c = `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_SHORT_NS));
    assign long_c = `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_LONG_NS));

    // ------------------------------------------------------------
    // wishbone slave, one wait state, write acts on the ack edge
    // ------------------------------------------------------------
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign go_tx = wr && wb_adr_i == `LBCS_ADR_TX && st_q == H_IDLE;
    assign go_det = wr && wb_adr_i == `LBCS_ADR_LINE &&
        wb_dat_i[`LBCS_LINE_DET] && st_q == H_IDLE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            case (wb_adr_i)
                `LBCS_ADR_LINE: wb_dat_o <= {31'h00000000, idle_q};
                `LBCS_ADR_STAT: begin
                    wb_dat_o <= {29'h00000000, ls2_q, ack_seen_q,
                        st_q != H_IDLE};
                end
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idle_q <= 1'b0;
        end else if (wr && wb_adr_i == `LBCS_ADR_LINE) begin
            idle_q <= wb_dat_i[`LBCS_LINE_LVL];
        end
    end

    // ------------------------------------------------------------
    // line sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        ls1_q <= link.line;
        ls2_q <= ls1_q;
    end

    always_comb begin
        case (st_q)
            H_START: lim = `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_START_NS));
            H_LO: lim = sh_q[7] ? short_c : long_c;
            H_HI: lim = sh_q[7] ? long_c : short_c;
            H_EOS: lim = `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_EOS_NS));
            H_ACKW: lim = `LBCS_CW'(`LBCS_CYC_MIN(`LBCS_H_SMP_NS));
            H_ACKS: lim = ACKMAX_CYC;
            H_DDLY: lim = DDLY_CYC;
            H_DLOW: lim = DLOW_CYC;
            default: lim = `LBCS_CW'(1);
        endcase
    end

    assign tdone = (cnt_q == lim - `LBCS_CW'(1));

    always_ff @(posedge clk_i) begin
        if (rst_i || tdone) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + `LBCS_CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= H_IDLE;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
        end else begin
            case (st_q)
                H_IDLE: begin
                    if (go_tx) begin
                        sh_q <= wb_dat_i[7:0];
                        bit_q <= 3'h0;
                        st_q <= H_START;
                    end else if (go_det) begin
                        st_q <= H_DDLY;
                    end
                end
                H_START: if (tdone) st_q <= H_LO;
                H_LO: if (tdone) st_q <= H_HI;
                H_HI: begin
                    if (tdone) begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 3'h1;
                        st_q <= (bit_q == 3'h7) ? H_EOS : H_LO;
                    end
                end
                H_EOS: if (tdone) st_q <= H_ACKW;
                H_ACKW: if (tdone) st_q <= H_ACKS;
                H_ACKS: if (ls2_q || tdone) st_q <= H_IDLE;
                H_DDLY: if (tdone) st_q <= H_DLOW;
                H_DLOW: if (tdone) st_q <= H_IDLE;
                default: st_q <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || go_tx) begin
            ack_seen_q <= 1'b0;
        end else if (st_q == H_ACKW && tdone && !ls2_q) begin
            ack_seen_q <= 1'b1;
        end
    end

    // line released during the ack window; the pull-up brings it high
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_q <= 1'b0;
            oe_q <= 1'b1;
        end else begin
            oe_q <= !(st_q == H_ACKW || st_q == H_ACKS);
            case (st_q)
                H_START, H_HI, H_DDLY: drv_q <= 1'b1;
                H_LO, H_EOS, H_DLOW: drv_q <= 1'b0;
                default: drv_q <= idle_q;
            endcase
        end
    end

    assign link.host_o = drv_q;
    assign link.host_oe = oe_q;
endmodule : lbcs_host
`default_nettype wire

// ===== tb/lbcs_asserts.sv
// concurrent checks on the control line and device outputs
`timescale 1ns/1ps
`default_nettype none
module lbcs_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic line,
    input wire logic switch_en_o,
    input wire logic ilim_half_o,
    input wire logic fault_o,
    input wire logic uvlo_i,
    input wire logic otp_i
);
    // ------------------------------------------------------------
    // line low run length, saturating so it never wraps to zero
    // ------------------------------------------------------------
    logic [10:0] low_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge clk_i) begin
        if (rst_i || line) low_q <= 11'h000;
        else if (low_q != 11'h7FF) low_q <= low_q + 11'h001;
    end
    a_ack_open_drain: assert property (dev_oe |-> !dev_o)
        else $error("device drove the line high");
    a_ack_bounded: assert property ($rose(dev_oe) |-> ##[1:601] !dev_oe)
        else $error("acknowledge held too long");
    a_ack_after_low: assert property ($rose(dev_oe) |-> !$past(line))
        else $error("acknowledge began on a high line");
    a_low_shutdown: assert property (low_q > 11'd1010 |-> !switch_en_o)
        else $error("switching during long low");
    a_uvlo_off: assert property (uvlo_i[*6] |-> !switch_en_o)
        else $error("switching under undervoltage");
    a_otp_off: assert property (otp_i[*6] |-> !switch_en_o)
        else $error("switching while hot");
    a_fault_off: assert property (fault_o[*2] |-> !switch_en_o)
        else $error("switching with fault latched");
    a_fault_held: assert property ((fault_o && !line)[*8] |=> fault_o)
        else $error("fault cleared without line rise");
    a_half_limit: assert property ($rose(ilim_half_o) |-> ##[1:310] !ilim_half_o)
        else $error("half limit held too long");
endmodule : lbcs_asserts
`default_nettype wire

// ===== tb/led_boost_control_sequencer_tb_top.sv
// self-checking bench: host and device joined over the control line
`timescale 1ns/1ps
`default_nettype none
module led_boost_control_sequencer_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic ovp = 1'b0, fbl = 1'b0, uvlo = 1'b0, otp = 1'b0;
    logic sw_en, ilim, onew, fault;
    logic [7:0] ref_code, b;
    int n_fail = 0, compares = 0, seed = 58, cycles = 0;
    lbcs_if link_if();
    // short detect low keeps every low phase below the off time
    lbcs_host #(.DLOW_CYC(18'd300)) lbcs_host_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .link(link_if));
    // off time must exceed the longest bit low phase of 480 cycles
    lbcs_device #(.OFF_CYC(18'd1000), .HALF_CYC(18'd300),
        .DET_CYC(18'd150), .ACK_CYC(18'd600)) lbcs_device_i (
        .clk_i(clk_i), .rst_i(rst_i), .link(link_if), .ovp_i(ovp),
        .fb_low_i(fbl), .uvlo_i(uvlo), .otp_i(otp), .switch_en_o(sw_en),
        .ilim_half_o(ilim), .ref_code_o(ref_code), .onewire_o(onew),
        .fault_o(fault));
    lbcs_asserts lbcs_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
        .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe), .line(link_if.line),
        .switch_en_o(sw_en), .ilim_half_o(ilim), .fault_o(fault),
        .uvlo_i(uvlo), .otp_i(otp));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR at %0t: saw %0h expected %0h", $time, s, e);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    function automatic logic exp_ack(input logic [7:0] f);
        return f[7];
    endfunction : exp_ack
    // level target scaled by the ramp step out of 32
    function automatic logic [7:0] exp_ref(input logic [7:0] f, input int s);
        return 8'(({f[4:0], f[4:2]} * s) / 32);
    endfunction : exp_ref
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        wt(20);
        rst_i <= 1'b0;
        wt(1);
        chk(sw_en | ilim | onew | fault, 1'b0);
        wb(1'b1, 8'h04, 32'h1, rd);
        wt(40);
        chk(ilim, 1'b1);
        // low byte not selected: the idle level write must be ignored
        sel <= 4'hE;
        wb(1'b1, 8'h04, 32'h0, rd);
        sel <= 4'hF;
        wt(5100);
        chk(sw_en, 1'b1);
        chk(onew, 1'b0);
        chk(ilim, 1'b0);
        $display("duty enable done");
        wb(1'b1, 8'h04, 32'h0, rd);
        wt(1100);
        chk(sw_en, 1'b0);
        wb(1'b1, 8'h04, 32'h3, rd);
        wt(6400);
        chk(onew, 1'b1);
        $display("detect done");
        for (int i = 0; i < 5; i++) begin
            b = (i == 0) ? 8'h80 : (i == 1) ? 8'h1F : 8'($random(seed));
            wb(1'b1, 8'h00, {24'h0, b}, rd);
            do wb(1'b0, 8'h08, 32'h0, rd); while (rd[0] !== 1'b0);
            chk(rd[1], exp_ack(b));
        end
        wb(1'b1, 8'h04, 32'h3, rd);
        wt(6400);
        chk(onew, 1'b1);
        $display("frames done");
        for (int k = 0; k < 2; k++) begin
            if (k == 0) uvlo <= 1'b1;
            else otp <= 1'b1;
            wt(10);
            chk(sw_en, 1'b0);
            uvlo <= 1'b0;
            otp <= 1'b0;
            wt(10);
            chk(sw_en, 1'b1);
            chk(ilim, 1'b1);
        end
        // one ramp step of 256 ticks after the restart, second not yet due
        wt(8500);
        chk(ref_code, exp_ref(b, 1));
        $display("supply and thermal done");
        // at most 7 ticks, then a gap longer than one tick, must not trip
        ovp <= 1'b1;
        fbl <= 1'b1;
        wt(215);
        chk(fault, 1'b0);
        ovp <= 1'b0;
        wt(40);
        ovp <= 1'b1;
        wt(300);
        chk(fault, 1'b1);
        chk(sw_en, 1'b0);
        ovp <= 1'b0;
        fbl <= 1'b0;
        wt(50);
        chk(fault, 1'b1);
        wb(1'b1, 8'h04, 32'h0, rd);
        wt(20);
        wb(1'b1, 8'h04, 32'h1, rd);
        wt(40);
        chk(fault, 1'b0);
        $display("open led done");
        wrap_up();
    end
endmodule : led_boost_control_sequencer_tb_top
`default_nettype wire
